// ### design/eivl_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

`include "eivl_params.svh"

// Operation
// - a port direction or option register access blanks edge detection one cycle
// - an edge during blanking sets no pending flag and raises no request
// - request arriving during an unmasked flags pop yields the reset vector
// - clearing a pending flag while its request is active may cause reset
// - clearing an enable mask never causes the unwanted reset
// - no reset when cleared in handler, by equal/higher level, or while disabled
module eivl_ctrl
    import eivl_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    // external interrupt pins and setup
    input  wire eivl_lines_t i_ext_pin,
    input  wire eivl_lines_t i_fall_sens,
    input  wire eivl_lines_t i_line_en,
    // port configuration access strobe
    input  wire logic        i_port_cfg_access,
    // software flag clear
    input  wire eivl_lines_t i_flag_clr,
    // cpu state
    input  wire logic        i_gmask,
    input  wire logic        i_pop_flags,
    input  wire logic        i_in_handler,
    input  wire logic        i_nested,
    input  wire eivl_prio_t  i_active_prio,
    // vector handshake
    input  wire logic        i_vec_ack,
    output logic             o_irq_req,
    output logic             o_vec_valid,
    output eivl_vec_t        o_vec_addr,
    // status
    output eivl_lines_t      o_pending,
    output logic             o_spur_reset
);

    // ********************************************************************
    // edge detection
    // ********************************************************************
    eivl_lines_t edge_det;
    eivl_lines_t pend_r;
    eivl_lines_t pend_nxt;
    eivl_lines_t ack_clr;
    eivl_lines_t clr_hazard;
    eivl_lines_t sel_line;
    logic        req_act;
    logic        vec_take;
    logic        src_lost_r;
    eivl_vec_t   sel_vec;

    eivl_edge_det u_edge
    (
        .i_sys_clk      (i_sys_clk),
        .i_arst_n       (i_arst_n),
        .i_pin          (i_ext_pin),
        .i_fall_sens    (i_fall_sens),
        .i_blank        (i_port_cfg_access),
        .o_edge         (edge_det)
    );

    // ********************************************************************
    // pending flags
    // ********************************************************************
    // a new edge wins over a clear in the same cycle
    always_comb
    begin
        pend_nxt = (pend_r & ~(i_flag_clr | ack_clr)) | edge_det;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pend_r <= `EIVL_PEND_RST;
        else
            pend_r <= pend_nxt;
    end

    assign o_pending = pend_r;
    assign req_act   = |(pend_r & i_line_en);
    // combinational request lets the cpu fetch in the cycle the flag lands
    assign o_irq_req = req_act && !i_gmask;
    assign vec_take  = o_irq_req && i_vec_ack;

    // ********************************************************************
    // vector selection
    // ********************************************************************
    // lowest line index has the highest priority
    always_comb
    begin
        sel_line = '0;
        sel_vec  = `EIVL_VEC_RESET;
        for (int i = `EIVL_NLINES - 1; i >= 0; i--)
        begin
            if (pend_r[i] && i_line_en[i])
            begin
                sel_line    = '0;
                sel_line[i] = 1'b1;
                sel_vec     = `EIVL_VEC_W'(`EIVL_VEC_BASE - (`EIVL_VEC_STEP * i));
            end
        end
    end

    assign ack_clr = vec_take ? sel_line : '0;

    // a request seen during an unmasked flags pop loses its source until fetched
    // the fetch consumes the lost request, even when it lands inside the pop
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            src_lost_r <= 1'b0;
        else if (vec_take)
            src_lost_r <= 1'b0;
        else if (i_pop_flags && req_act && !i_gmask)
            src_lost_r <= 1'b1;
    end

    // the address holds between fetches; only valid marks a fresh vector
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_vec_valid <= 1'b0;
            o_vec_addr  <= `EIVL_VEC_RST;
        end
        else
        begin
            o_vec_valid <= vec_take;
            if (vec_take)
                o_vec_addr <= (src_lost_r || i_pop_flags) ? `EIVL_VEC_RESET : sel_vec;
        end
    end

    // ********************************************************************
    // unwanted reset on flag clear
    // ********************************************************************
    // only a flag clear counts; the enable input is never looked at as a trigger
    genvar g;
    generate
        for (g = 0; g < `EIVL_NLINES; g++)
        begin : g_haz
            localparam eivl_prio_t LPRIO = eivl_prio_t'(`EIVL_NLINES - 1 - g);
            // line 0 carries the top priority level
            logic safe;
            assign safe = !i_line_en[g] || i_gmask ||
                (i_in_handler && (!i_nested || i_active_prio >= LPRIO));
            assign clr_hazard[g] = i_flag_clr[g] && pend_r[g] && !safe;
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_spur_reset <= 1'b0;
        else
            o_spur_reset <= |clr_hazard;
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    blank_no_edge_a: assert property (i_port_cfg_access |-> edge_det == '0)
        else $error("edge detected during blanking");
    blank_one_cycle_a: assert property
        (!i_port_cfg_access && !i_fall_sens[0] && $rose(i_ext_pin[0]) |-> ##1 pend_r[0])
        else $error("edge outside blanking not caught");
    edge_sets_flag_a: assert property
        (edge_det != '0 |=> (pend_r & $past(edge_det)) == $past(edge_det))
        else $error("detected edge set no flag");
    blanked_lost_a: assert property
        (i_port_cfg_access && !pend_r[0] && $rose(i_ext_pin[0]) |=> !pend_r[0])
        else $error("blanked edge set a flag");
    pop_reset_vec_a: assert property
        (i_pop_flags && req_act && !i_gmask && i_vec_ack
         |=> o_vec_valid && o_vec_addr == `EIVL_VEC_RESET)
        else $error("lost source did not give reset vector");
    lost_fetch_clr_a: assert property (vec_take |=> !src_lost_r)
        else $error("lost source survived a fetch");
    masked_pop_a: assert property
        (i_pop_flags && i_gmask && !src_lost_r |=> !src_lost_r)
        else $error("masked flags pop lost the source");
    known_vec_a: assert property
        (vec_take && !src_lost_r && !i_pop_flags && sel_line[0]
         |=> o_vec_addr == `EIVL_VEC_BASE)
        else $error("line 0 fetch gave the wrong vector");
    clear_reset_a: assert property
        (i_flag_clr[0] && pend_r[0] && i_line_en[0] && !i_gmask && !i_in_handler
         |=> o_spur_reset)
        else $error("unsafe clear gave no reset");
    mask_clear_safe_a: assert property (i_flag_clr == '0 |=> !o_spur_reset)
        else $error("reset without a flag clear");
    handler_safe_a: assert property (i_in_handler && !i_nested |=> !o_spur_reset)
        else $error("reset raised inside a handler");
    gmask_hold_a: assert property (i_gmask |-> !o_irq_req ##1 !o_vec_valid)
        else $error("vector delivered while masked");
    vec_hold_a: assert property (!vec_take |=> $stable(o_vec_addr))
        else $error("vector changed without a fetch");

    // main scenarios
    normal_vec_c: cover property (vec_take ##1 o_vec_addr != `EIVL_VEC_RESET);
    pop_hazard_c: cover property (i_pop_flags && req_act && !i_gmask);
    pop_fetch_c: cover property (i_pop_flags && vec_take);
    masked_pop_c: cover property (i_pop_flags && i_gmask && req_act);
    spur_reset_c: cover property (o_spur_reset);

endmodule

`default_nettype wire

// ### design/eivl_params.svh
`ifndef EIVL_PARAMS_SVH
`define EIVL_PARAMS_SVH

// number of external interrupt lines
`define EIVL_NLINES      4
// width of a vector address
`define EIVL_VEC_W       16
// vector fetched when the source is lost
`define EIVL_VEC_RESET   16'hFFFE
// vector of line 0; each higher line sits one word below
`define EIVL_VEC_BASE    16'hFFF6
`define EIVL_VEC_STEP    16'h0002
// length of the detector blanking during a port configuration access, in cycles
`define EIVL_BLANK_CYC   1
// reset values
`define EIVL_PEND_RST    4'h0
`define EIVL_VEC_RST     16'h0000

`endif

// ### design/eivl_pkg.sv
`include "eivl_params.svh"

package eivl_pkg;
    typedef logic [`EIVL_NLINES-1:0] eivl_lines_t;
    typedef logic [`EIVL_VEC_W-1:0]  eivl_vec_t;
    typedef logic [1:0]              eivl_prio_t;
endpackage

// ### design/eivl_edge_det.sv
`timescale 1ns/1ps
`default_nettype none

`include "eivl_params.svh"

module eivl_edge_det
    import eivl_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    // pins and sensitivity
    input  wire eivl_lines_t i_pin,
    input  wire eivl_lines_t i_fall_sens,
    // blanking
    input  wire logic        i_blank,
    // detected edges
    output eivl_lines_t      o_edge
);

    eivl_lines_t pin_prev_r;

    // the previous level keeps tracking while blanked, so a blanked edge is gone for good
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pin_prev_r <= `EIVL_PEND_RST;
        else
            pin_prev_r <= i_pin;
    end

    genvar g;
    generate
        for (g = 0; g < `EIVL_NLINES; g++)
        begin : g_line
            assign o_edge[g] = !i_blank &&
                (i_fall_sens[g] ? (pin_prev_r[g] && !i_pin[g])
                                : (!pin_prev_r[g] && i_pin[g]));
        end
    endgenerate

endmodule

`default_nettype wire

// ### verification/eivl_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module eivl_cpu_model
(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_arst_n,
    // fetch permission and request
    input  wire logic i_go,
    input  wire logic i_irq_req,
    // vector fetch
    output logic      o_vec_ack
);
    // fetch one cycle after a request shows; a late ack after the take is ignored
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_vec_ack <= 1'b0;
        else
            o_vec_ack <= i_go & i_irq_req;
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "eivl_params.svh"
module testbench
    import eivl_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0, cfg = 1'b0, gmask = 1'b0, pop = 1'b0;
    logic inh = 1'b0, nest = 1'b0, ack, go = 1'b0, req, vv, spur;
    logic chg = 1'b0;
    eivl_lines_t pin, sens, en = 4'hF, clr = 4'h0, pend;
    eivl_prio_t prio = 2'h0;
    eivl_vec_t va;
    int failures = 0, checked = 0;
    always #10 clk = ~clk;
    eivl_ctrl eivl_ctrl_i (.i_sys_clk(clk), .i_arst_n(arst_n), .i_ext_pin(pin),
        .i_fall_sens(sens), .i_line_en(en), .i_port_cfg_access(cfg), .i_flag_clr(clr),
        .i_gmask(gmask), .i_pop_flags(pop), .i_in_handler(inh), .i_nested(nest),
        .i_active_prio(prio), .i_vec_ack(ack), .o_irq_req(req), .o_vec_valid(vv),
        .o_vec_addr(va), .o_pending(pend), .o_spur_reset(spur));
    eivl_cpu_model eivl_cpu_model_i (.i_sys_clk(clk), .i_arst_n(arst_n), .i_go(go),
        .i_irq_req(req), .o_vec_ack(ack));
    // ****************************************
    // helpers
    // ****************************************
    task automatic t();
        @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [15:0] ev(input int i);
        return `EIVL_VEC_BASE - 16'(i) * `EIVL_VEC_STEP;
    endfunction
    function automatic logic sp(input int i, input logic h, n, input logic [1:0] p);
        return !(h && (!n || p >= 2'(3 - i)));
    endfunction
    // toggle a line to its active level; the pin returns idle one cycle later
    task automatic fire(input int i, input logic b);
        t();
        pin[i] = ~pin[i];
        cfg = b;
        t();
        chg = (pin[i] != sens[i]);
        cfg = 1'b0;
        pin[i] = ~pin[i];
    endtask
    task automatic pc(input int i);
        clr = 4'(1 << i);
        t();
        clr = 4'h0;
    endtask
    task automatic wait_vec(input logic [15:0] exp);
        int k;
        k = 0;
        while (vv !== 1'b1 && k < 10)
        begin
            t();
            k++;
        end
        chk("vec_valid", vv, 16'h1);
        chk("vec_addr", va, exp);
    endtask
    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        #100000;
        failures++;
        conclude();
    end
    initial
    begin
        int i;
        logic h, n;
        logic [1:0] p;
        void'($urandom(32'h151407a3));
        sens = 4'($urandom);
        pin = sens;
        repeat (8) t();
        arst_n = 1'b1;
        for (int r = 0; r < 20; r++)
        begin
            i = $urandom % 4;
            go = 1'b1;
            fire(i, 1'b0);
            // software semaphore: level moved yet no flag came, so the handler is owed a call
            chk("missed_edge", 16'(chg && !pend[i]), 16'h0);
            wait_vec(ev(i));
            chk("pending", pend, 16'h0);
            fire(i, 1'b1);
            chk("pending", pend, 16'h0);
            chk("missed_edge", 16'(chg && !pend[i]), 16'h1);
            go = 1'b0;
            gmask = 1'b1;
            fire(i, 1'b0);
            go = 1'b1;
            repeat (3) t();
            chk("irq_req", req, 16'h0);
            chk("vec_valid", vv, 16'h0);
            chk("pending", pend, 16'(1 << i));
            pc(i);
            chk("spur_reset", spur, 16'h0);
            go = 1'b0;
            gmask = 1'b0;
            fire(i, 1'b0);
            {h, n, p} = 4'($urandom);
            if (r < 2)
                h = r[0];
            inh = h;
            nest = n;
            prio = p;
            pc(i);
            chk("spur_reset", spur, 16'(sp(i, h, n, p)));
            t();
            chk("spur_reset", spur, 16'h0);
            inh = 1'b0;
            fire(i, 1'b0);
            en[i] = 1'b0;
            t();
            chk("spur_reset", spur, 16'h0);
            pc(i);
            chk("spur_reset", spur, 16'h0);
            en = 4'hF;
            fire(i, 1'b0);
            // on odd rounds the fetch lands inside the pop itself
            go = r[0];
            pop = 1'b1;
            repeat (2) t();
            pop = 1'b0;
            go = 1'b1;
            wait_vec(`EIVL_VEC_RESET);
            t();
            chk("pending", pend, 16'h0);
            go = 1'b0;
            fire(i, 1'b0);
            gmask = 1'b1;
            pop = 1'b1;
            t();
            gmask = 1'b0;
            pop = 1'b0;
            go = 1'b1;
            wait_vec(ev(i));
            t();
            chk("pending", pend, 16'h0);
            $display("test %0d done", r);
        end
        conclude();
    end
endmodule
`default_nettype wire
